//--- rtl/lqm_cmp_if.sv
// one parameter with its two thresholds and the comparison result
`timescale 1ns/10ps
`default_nettype none
`include "lqm_regs.svh"

interface lqm_cmp_if;
  logic signed [`LQM_PARAM_W-1:0] value;
  logic signed [`LQM_PARAM_W-1:0] thr_lo;
  logic signed [`LQM_PARAM_W-1:0] thr_hi;
  logic viol_hi;
  logic viol_lo;
  modport cmp (input value, input thr_lo, input thr_hi, output viol_hi, output viol_lo);
  modport ctl (output value, output thr_lo, output thr_hi, input viol_hi, input viol_lo);
endinterface

`default_nettype wire

//--- rtl/lqm_compare.sv
// threshold comparator for one monitored parameter
`timescale 1ns/10ps
`default_nettype none

module lqm_compare (
  lqm_cmp_if.cmp port
);
  // strict compares: a threshold at the type's extreme can never be passed
  always_comb begin
    port.viol_hi = port.value > port.thr_hi;
    port.viol_lo = port.value < port.thr_lo;
  end
endmodule

`default_nettype wire

//--- rtl/lqm_pkg.sv
// types shared by the link quality monitor files
`default_nettype none
`include "lqm_regs.svh"

package lqm_pkg;

  typedef logic signed [`LQM_PARAM_W-1:0] lqm_param_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [`LQM_NUM_FLAGS-1:0] flags;
    lqm_param_t [2*`LQM_NUM_PARAMS-1:0] thr;
    logic irq_en;
    logic sd_opt;
    logic irq;
    logic armed;
    logic dsp_restart;
    logic link_drop;
    logic awready;
    logic aw_full;
    logic [`LQM_ADDR_W-1:0] awaddr;
    logic wready;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lqm_state_t;

endpackage

`default_nettype wire

//--- rtl/lqm_regs.svh
// register offsets, field positions, reset values and sizes of the link monitor
`ifndef LQM_REGS_SVH
`define LQM_REGS_SVH

`define LQM_ADDR_W 8
`define LQM_PARAM_W 16
`define LQM_NUM_PARAMS 5
`define LQM_NUM_FLAGS 10

// printed register index; byte address is four times it
`define LQM_CS_INDEX 8'h1D
`define LQM_CS_ADDR 8'h74
`define LQM_CFG_ADDR 8'h78
`define LQM_STAT_ADDR 8'h7C
`define LQM_THR_BASE 8'h80
`define LQM_THR_LAST 8'hA4

// control/status fields
`define LQM_MON_ENABLE_BIT 15
`define LQM_RESTART_LSB 10
`define LQM_CS_RESET 16'h0000
`define LQM_CS_WR_MASK 16'hFC00

// parameter selector codes
`define LQM_SEL_EQUALIZER 3'h0
`define LQM_SEL_GAIN 3'h1
`define LQM_SEL_WANDER 3'h2
`define LQM_SEL_OFFSET 3'h3
`define LQM_SEL_FREQ_CTRL 3'h4

// config fields
`define LQM_CFG_IRQ_EN_BIT 0
`define LQM_CFG_SD_OPT_BIT 1

// thresholds reset to their extremes so no check fires until programmed
`define LQM_THR_LO_RESET 16'h8000
`define LQM_THR_HI_RESET 16'h7FFF

`define LQM_RESP_OKAY 2'h0
`define LQM_RESP_SLVERR 2'h2

`endif

//--- rtl/lqm_top.sv
// link quality monitor: threshold checks, warning flags, restart and axi4-lite registers
// Operation
// - monitor checks thresholds only when enabled and a valid 100 Mb link exists
// - threshold at max or min value never reports a violation
// - a violation raises the interrupt when its enable is set
// - reading the monitor register returns flags, clears them and re-arms the interrupt
// - restart bits 14..10 reset the DSP and restart adaptation on that violation
// - restart-enabled violation also drops link when signal detect option is 0
// - frequency control high sets bit 9, low sets bit 8
// - frequency offset high sets bit 7, low sets bit 6
// - baseline wander high sets bit 5, low sets bit 4
// - digital gain high sets bit 3, low sets bit 2
// - equalizer coefficient high sets bit 1, low sets bit 0
// - thresholds selected by 3-bit parameter code plus low/high bit
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "lqm_regs.svh"

module lqm_top
  import lqm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`LQM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`LQM_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_100_valid,
  input wire lqm_param_t equalizer_coeff_param,
  input wire lqm_param_t digital_gain_param,
  input wire lqm_param_t baseline_wander_param,
  input wire lqm_param_t offset_param,
  input wire lqm_param_t freq_control_param,
  output logic monitor_irq,
  output logic dsp_restart,
  output logic link_drop
);

  // ==========================================================================
  // reset image
  // ==========================================================================
  localparam lqm_state_t RESET_STATE = '{
    ctrl: `LQM_CS_RESET,
    flags: '0,
    thr: {`LQM_NUM_PARAMS{`LQM_THR_HI_RESET, `LQM_THR_LO_RESET}},
    irq_en: 1'b0,
    sd_opt: 1'b0,
    irq: 1'b0,
    armed: 1'b1,
    dsp_restart: 1'b0,
    link_drop: 1'b0,
    // ready flags start high so a request is taken at the first edge after reset
    awready: 1'b1,
    aw_full: 1'b0,
    awaddr: '0,
    wready: 1'b1,
    w_full: 1'b0,
    wdata: '0,
    wstrb: '0,
    bvalid: 1'b0,
    bresp: `LQM_RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rdata: '0,
    rresp: `LQM_RESP_OKAY
  };

  lqm_state_t s_reg;
  lqm_state_t s_next;

  // ==========================================================================
  // comparators, one per parameter, indexed by selector code
  // ==========================================================================
  lqm_param_t [`LQM_NUM_PARAMS-1:0] param_vec;
  logic [`LQM_NUM_FLAGS-1:0] viol;

  always_comb begin
    param_vec[`LQM_SEL_EQUALIZER] = equalizer_coeff_param;
    param_vec[`LQM_SEL_GAIN] = digital_gain_param;
    param_vec[`LQM_SEL_WANDER] = baseline_wander_param;
    param_vec[`LQM_SEL_OFFSET] = offset_param;
    param_vec[`LQM_SEL_FREQ_CTRL] = freq_control_param;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `LQM_NUM_PARAMS; gi = gi + 1) begin : g_cmp
      lqm_cmp_if cmp_bus ();
      assign cmp_bus.value = param_vec[gi];
      assign cmp_bus.thr_lo = s_reg.thr[2*gi];
      assign cmp_bus.thr_hi = s_reg.thr[2*gi+1];
      // low flag at bit 2p, high flag at bit 2p+1
      assign viol[2*gi] = cmp_bus.viol_lo;
      assign viol[2*gi+1] = cmp_bus.viol_hi;
      lqm_compare u_cmp (
        .port(cmp_bus)
      );
    end
  endgenerate

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [15:0] apply_strb(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  function automatic logic thr_hit(input logic [`LQM_ADDR_W-1:0] a);
    return (a >= `LQM_THR_BASE) && (a <= `LQM_THR_LAST) && (a[1:0] == 2'h0);
  endfunction

  // ==========================================================================
  // address decode
  // ==========================================================================
  // a write commits at the edge that takes its last half unless a response is pending, so decode the address
  // that will be held after this edge, not the one held now
  logic [`LQM_ADDR_W-1:0] wa;
  logic [`LQM_ADDR_W-1:0] ra;
  logic wa_cs;
  logic wa_cfg;
  logic wa_stat;
  logic wa_thr;
  logic ra_cs;
  logic ra_cfg;
  logic ra_stat;
  logic ra_thr;

  always_comb begin
    wa = (s_reg.awready && s_axi_awvalid) ? s_axi_awaddr : s_reg.awaddr;
    ra = s_axi_araddr;
    wa_cs = wa == `LQM_CS_ADDR;
    wa_cfg = wa == `LQM_CFG_ADDR;
    wa_stat = wa == `LQM_STAT_ADDR;
    wa_thr = thr_hit(wa);
    ra_cs = ra == `LQM_CS_ADDR;
    ra_cfg = ra == `LQM_CFG_ADDR;
    ra_stat = ra == `LQM_STAT_ADDR;
    ra_thr = thr_hit(ra);
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  logic mon_active;
  logic rd_clear;
  logic [`LQM_NUM_FLAGS-1:0] new_viol;
  logic [`LQM_NUM_PARAMS-1:0] restart_hit;
  logic [3:0] thr_idx;

  always_comb begin
    s_next = s_reg;
    s_next.dsp_restart = 1'b0;
    s_next.link_drop = 1'b0;
    rd_clear = 1'b0;
    thr_idx = 4'h0;

    // write address and data are taken independently
    if (s_reg.awready && s_axi_awvalid) begin
      s_next.aw_full = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_reg.wready && s_axi_wvalid) begin
      s_next.w_full = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_next.aw_full && s_next.w_full && !s_next.bvalid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `LQM_RESP_OKAY;
      if (wa_cs) begin
        // warning flags are read-only; only enable and restart bits store
        s_next.ctrl = apply_strb(s_reg.ctrl, s_next.wdata, s_next.wstrb) & `LQM_CS_WR_MASK;
      end else if (wa_cfg) begin
        if (s_next.wstrb[0]) begin
          s_next.irq_en = s_next.wdata[`LQM_CFG_IRQ_EN_BIT];
          s_next.sd_opt = s_next.wdata[`LQM_CFG_SD_OPT_BIT];
        end
      end else if (wa_thr) begin
        thr_idx = 4'((wa - `LQM_THR_BASE) >> 2);
        s_next.thr[thr_idx] = apply_strb(s_reg.thr[thr_idx], s_next.wdata, s_next.wstrb);
      end else if (!wa_stat) begin
        s_next.bresp = `LQM_RESP_SLVERR;
      end
    end
    // a held half blocks its channel until the pair commits
    s_next.awready = !s_next.aw_full;
    s_next.wready = !s_next.w_full;

    // read: data captured at the address handshake
    // one read in flight: a new address waits until the data is taken
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (s_reg.arready && s_axi_arvalid) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = `LQM_RESP_OKAY;
      s_next.rdata = '0;
      if (ra_cs) begin
        s_next.rdata[15:0] = s_reg.ctrl | 16'(s_reg.flags);
        rd_clear = 1'b1;
      end else if (ra_cfg) begin
        s_next.rdata[`LQM_CFG_IRQ_EN_BIT] = s_reg.irq_en;
        s_next.rdata[`LQM_CFG_SD_OPT_BIT] = s_reg.sd_opt;
      end else if (ra_stat) begin
        s_next.rdata[3:0] = {link_100_valid, mon_active, s_reg.armed, s_reg.irq};
      end else if (ra_thr) begin
        thr_idx = 4'((ra - `LQM_THR_BASE) >> 2);
        s_next.rdata[15:0] = s_reg.thr[thr_idx];
      end else begin
        s_next.rresp = `LQM_RESP_SLVERR;
      end
    end

    // monitor: flags latch and a read clears them; a same-cycle event still sets
    new_viol = viol & {`LQM_NUM_FLAGS{mon_active}};
    s_next.flags = (rd_clear ? '0 : s_reg.flags) | new_viol;

    // interrupt fires once, then waits for a read to re-arm it
    if (rd_clear) begin
      s_next.irq = 1'b0;
      s_next.armed = 1'b1;
    end
    if (|new_viol && s_reg.irq_en && (s_reg.armed || rd_clear)) begin
      s_next.irq = 1'b1;
      s_next.armed = 1'b0;
    end

    // restart only on a freshly set flag so a lasting violation does not loop the DSP
    for (int p = 0; p < `LQM_NUM_PARAMS; p++) begin
      restart_hit[p] = s_reg.ctrl[`LQM_RESTART_LSB+p] &&
                       |(new_viol[2*p +: 2] & ~s_reg.flags[2*p +: 2]);
    end
    s_next.dsp_restart = |restart_hit;
    s_next.link_drop = |restart_hit && !s_reg.sd_opt;
  end

  assign mon_active = s_reg.ctrl[`LQM_MON_ENABLE_BIT] && link_100_valid;

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign monitor_irq = s_reg.irq;
  assign dsp_restart = s_reg.dsp_restart;
  assign link_drop = s_reg.link_drop;

endmodule

`default_nettype wire

//--- tb/lqm_properties.sv
// port-level assertions for the link quality monitor
`timescale 1ns/10ps
`default_nettype none
`include "lqm_regs.svh"

module lqm_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`LQM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_100_valid,
  input wire logic monitor_irq,
  input wire logic dsp_restart,
  input wire logic link_drop
);
  // ==========================
  // read handshake decode
  wire logic ar_go;
  wire logic cs_go;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign cs_go = ar_go && (s_axi_araddr == `LQM_CS_ADDR);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // no link in the read cycle means nothing can re-set a flag at the clearing edge
  sequence quiet_read;
    cs_go && !link_100_valid;
  endsequence
  sequence read_answer;
    ar_go ##1 s_axi_rvalid;
  endsequence
  // ==========================
  // assertions
  irq_needs_link_a: assert property ($rose(monitor_irq) |-> $past(link_100_valid)) else $error("irq without link");
  irq_holds_a: assert property (monitor_irq && !cs_go |=> monitor_irq) else $error("irq dropped early");
  irq_clear_a: assert property (quiet_read |=> !monitor_irq) else $error("irq kept after read");
  restart_pulse_a: assert property (dsp_restart |=> !dsp_restart) else $error("restart too long");
  restart_link_a: assert property (dsp_restart |-> $past(link_100_valid)) else $error("restart no link");
  drop_with_a: assert property (link_drop |-> dsp_restart) else $error("drop without restart");
  read_timing_a: assert property (ar_go |-> read_answer) else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
  unmapped_read_a: assert property (ar_go && s_axi_araddr == 8'h00 |=> s_axi_rresp == `LQM_RESP_SLVERR)
    else $error("unmapped not refused");
endmodule

bind lqm_top lqm_properties u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .link_100_valid(link_100_valid), .monitor_irq(monitor_irq), .dsp_restart(dsp_restart), .link_drop(link_drop));

`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the link quality monitor
`timescale 1ns/10ps
`default_nettype none
`include "lqm_regs.svh"

module tb;
  import lqm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, link_ok = 1'b0;
  lqm_param_t prm [5] = '{default: 16'h0000};
  logic awready, wready, bvalid, arready, rvalid, irq, restart, drop;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd_data;
  logic [1:0] rd_resp;
  logic [7:0] ta;
  int mismatches = 0, n_checks = 0, n_restart = 0, n_drop = 0;

  always #5 aclk = ~aclk;
  // pulses are counted off the edge so the count never races the register update
  always @(negedge aclk) begin
    if (restart === 1'b1) n_restart++;
    if (drop === 1'b1) n_drop++;
  end

  lqm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link_100_valid(link_ok), .equalizer_coeff_param(prm[0]),
    .digital_gain_param(prm[1]), .baseline_wander_param(prm[2]), .offset_param(prm[3]),
    .freq_control_param(prm[4]), .monitor_irq(irq), .dsp_restart(restart), .link_drop(drop));

  // ==========================
  // bus and check tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // handshakes are sampled at the falling edge, where registered outputs equal their rising-edge value
  task automatic wr_resp(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ka, kw, got;
    logic [1:0] br;
    int i;
    got = 1'b0;
    br = 2'h0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && !got; i++) begin
      @(negedge aclk);
      ka = awvalid && awready;
      kw = wvalid && wready;
      got = (bvalid === 1'b1);
      br = bresp;
      @(posedge aclk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
      if (got) bready <= 1'b0;
    end
    if (!got) begin
      mismatches++;
      report_and_stop();
    end
    chk("bresp", {30'h0, br}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wr_resp(a, d, 2'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ka, got, rv;
    int i;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    // rready follows rvalid by a cycle so the slave must hold its read data
    for (i = 0; i < 50 && !got; i++) begin
      @(negedge aclk);
      ka = arvalid && arready;
      rv = (rvalid === 1'b1);
      got = rv && rready;
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge aclk);
      if (ka) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
      else if (rv) rready <= 1'b1;
    end
    if (!got) begin
      mismatches++;
      report_and_stop();
    end
    chk("rdata", rd_data, e);
    chk("rresp", {30'h0, rd_resp}, {30'h0, er});
    @(posedge aclk);
  endtask

  // ==========================
  // scenarios
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h74, 32'h00000000, 2'h0);
    rd(8'h80, 32'h00008000, 2'h0);
    rd(8'h00, 32'h00000000, 2'h2);
    wr_resp(8'h00, 16'hFFFF, 2'h2);
    wr_resp(8'h7C, 16'hFFFF, 2'h0);
    wr(8'h78, 16'h0001);
    wr(8'h74, 16'hFFFF);
    rd(8'h74, 32'h0000FC00, 2'h0);
    link_ok <= 1'b1;
    for (int p = 0; p < 5; p++) begin
      for (int hl = 0; hl < 2; hl++) begin
        ta = 8'h80 + 8'(8 * p + 4 * hl);
        wr(ta, (hl == 1) ? 16'h0010 : 16'hFFF0);
        prm[p] <= (hl == 1) ? 16'h0020 : 16'hFFE0;
        tick(3);
        prm[p] <= 16'h0000;
        tick(3);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(8'h74, 32'h0000FC00 | (32'h1 << (2 * p + hl)), 2'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(ta, (hl == 1) ? 16'h7FFF : 16'h8000);
      end
    end
    chk("restarts", 32'(n_restart), 32'd10);
    chk("drops", 32'(n_drop), 32'd10);
    wr(8'h78, 16'h0003);
    rd(8'h78, 32'h00000003, 2'h0);
    wr(8'h8C, 16'h0010);
    prm[1] <= 16'h0020;
    tick(3);
    prm[1] <= 16'h0000;
    tick(3);
    chk("restarts", 32'(n_restart), 32'd11);
    chk("drops", 32'(n_drop), 32'd10);
    rd(8'h7C, 32'h0000000D, 2'h0);
    rd(8'h74, 32'h0000FC08, 2'h0);
    wr(8'h78, 16'h0002);
    wr(8'h74, 16'hF400);
    prm[1] <= 16'h0020;
    tick(3);
    prm[1] <= 16'h0000;
    tick(3);
    chk("irq", {31'h0, irq}, 32'h0);
    chk("restarts", 32'(n_restart), 32'd11);
    rd(8'h74, 32'h0000F408, 2'h0);
    wr(8'h74, 16'hFC00);
    prm[1] <= 16'h0020;
    link_ok <= 1'b0;
    tick(3);
    rd(8'h74, 32'h0000FC00, 2'h0);
    wr(8'h74, 16'h7C00);
    link_ok <= 1'b1;
    tick(3);
    rd(8'h74, 32'h00007C00, 2'h0);
    wr(8'h8C, 16'h7FFF);
    wr(8'h74, 16'hFC00);
    prm <= '{default: 16'h7FFF};
    tick(3);
    prm <= '{default: 16'h8000};
    tick(3);
    rd(8'h74, 32'h0000FC00, 2'h0);
    chk("restarts", 32'(n_restart), 32'd11);
    report_and_stop();
  end
endmodule

`default_nettype wire
